//--- rtl/seq_slots_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 40 MHz system clock
// Notes:   definitions only
`ifndef SEQ_SLOTS_MAP_SVH
`define SEQ_SLOTS_MAP_SVH

`define SEQ_CTRL_OFFSET      8'h0c
`define SEQ_FIRST_OFFSET     8'h0f
`define SEQ_SLOT3_OFFSET     8'h11
`define SEQ_SLOT4_OFFSET     8'h12
`define SEQ_LAST_OFFSET      8'h16
`define SEQ_SLOT_RESET       8'h00
`define SEQ_FLAG_BIT         7
`define SEQ_VALUE_MSB        6
`define SEQ_NUM_SLOTS        8
`define SEQ_STEP_TIME_US     10000
`define SEQ_CLK_MHZ          40
`define SEQ_STEP_CYCLES      (`SEQ_STEP_TIME_US * `SEQ_CLK_MHZ)

`endif

//--- rtl/seq_slots_pkg.sv
// Purpose: types shared by the sequence slot bank
// Assumes: nothing beyond the map header
// Notes:   one-hot sequencer states
package seq_slots_pkg;

  typedef struct packed {
    logic       delay_flag;
    logic [6:0] value;
  } slot_t;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_PLAY  = 4'b0100,
    ST_WAIT  = 4'b1000
  } seq_state_t;

endpackage : seq_slots_pkg

//--- rtl/waveform_sequence_slots_3_4.sv
// Purpose: slots three and four of the playback sequence, plus the sequencer walk
// Assumes: register port comes from the serial slave decoder, synchronous to i_clk_sys
// Notes:   the other six slots arrive from their own banks on i_other_slots
`include "seq_slots_map.svh"

module waveform_sequence_slots_3_4 #(
  parameter int unsigned STEP_CYCLES = `SEQ_STEP_CYCLES
) (
  // clock, reset, enable
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset,
  input  wire logic                        i_ce,
  // register access
  input  wire seq_slots_pkg::reg_wr_t      i_reg_wr,
  input  wire logic                        i_rd_en,
  input  wire logic [7:0]                  i_rd_addr,
  output logic      [7:0]                  o_rd_data,
  output logic                             o_rd_hit,
  // neighbouring slots: 0x0f, 0x10, 0x13..0x16 in that order
  input  wire seq_slots_pkg::slot_t [5:0]  i_other_slots,
  input  wire logic                        i_go,
  // playback engine
  input  wire logic                        i_wave_done,
  output logic                             o_wave_start,
  output logic      [6:0]                  o_wave_id,
  output logic      [2:0]                  o_slot_idx,
  output logic                             o_busy,
  output logic                             o_waiting
);
  import seq_slots_pkg::*;

  localparam int unsigned TW = $clog2(STEP_CYCLES + 1);

  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("STEP_CYCLES must be at least one");
  end

  // a zero identifier ends the walk, whatever the flag says
  function automatic logic is_stop(input slot_t s);
    return s.value == 7'h00;
  endfunction : is_stop

  slot_t      local_q [1:0];
  slot_t      entries [7:0];
  seq_state_t state_q;
  logic [2:0] idx_q;
  logic [6:0] steps_q;
  logic [TW-1:0] tick_q;

  // register writes, one 8-bit register per local slot
  genvar g;
  for (g = 0; g < 2; g++) begin : g_slot
    wire logic hit = i_reg_wr.wr_en && (i_reg_wr.addr == `SEQ_SLOT3_OFFSET + 8'(g));
    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        local_q[g] <= slot_t'(`SEQ_SLOT_RESET);
      end else if (i_ce && hit) begin
        local_q[g] <= slot_t'(i_reg_wr.wdata);
      end
    end
  end

  assign entries[0] = i_other_slots[0];
  assign entries[1] = i_other_slots[1];
  assign entries[2] = local_q[0];
  assign entries[3] = local_q[1];
  assign entries[4] = i_other_slots[2];
  assign entries[5] = i_other_slots[3];
  assign entries[6] = i_other_slots[4];
  assign entries[7] = i_other_slots[5];

  wire logic rd_slot3 = (i_rd_addr == `SEQ_SLOT3_OFFSET);
  wire logic rd_slot4 = (i_rd_addr == `SEQ_SLOT4_OFFSET);
  wire logic [7:0] rd_mux = rd_slot3 ? 8'(local_q[0]) : rd_slot4 ? 8'(local_q[1]) : 8'h00;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rd_data <= 8'h00;
      o_rd_hit  <= 1'b0;
    end else if (i_ce) begin
      o_rd_data <= i_rd_en ? rd_mux : 8'h00;
      o_rd_hit  <= i_rd_en && (rd_slot3 || rd_slot4);
    end
  end

  // sequencer decode
  wire slot_t cur       = entries[idx_q];
  wire logic  last_slot = (idx_q == 3'(`SEQ_NUM_SLOTS - 1));
  wire logic  tick_end  = (tick_q == TW'(STEP_CYCLES - 1));
  wire logic  wait_exp  = tick_end && (steps_q == 7'h01);
  wire logic  advance   = (state_q == ST_PLAY && i_wave_done) || (state_q == ST_WAIT && wait_exp);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_q      <= ST_IDLE;
      idx_q        <= 3'h0;
      steps_q      <= 7'h00;
      tick_q       <= '0;
      o_wave_start <= 1'b0;
      o_wave_id    <= 7'h00;
    end else if (i_ce) begin
      o_wave_start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_go) begin
            idx_q   <= 3'h0;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (is_stop(cur)) begin
            state_q <= ST_IDLE;
          end else if (cur.delay_flag) begin
            steps_q <= cur.value;
            tick_q  <= '0;
            state_q <= ST_WAIT;
          end else begin
            o_wave_start <= 1'b1;
            o_wave_id    <= cur.value;
            state_q      <= ST_PLAY;
          end
        end
        ST_PLAY, ST_WAIT: begin
          if (state_q == ST_WAIT) begin
            tick_q <= tick_end ? '0 : tick_q + TW'(1);
            if (tick_end) begin
              steps_q <= steps_q - 7'h01;
            end
          end
          if (advance) begin
            state_q <= last_slot ? ST_IDLE : ST_FETCH;
            idx_q   <= last_slot ? idx_q : idx_q + 3'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_slot_idx = idx_q;
  assign o_busy     = (state_q != ST_IDLE);
  assign o_waiting  = (state_q == ST_WAIT);

  // checks: ce is held high where the figures below are exact
  chk_wait_no_play: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q == ST_WAIT) |=> !o_wave_start)
    else $error("waveform started during a wait");

  chk_wait_length: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && state_q == ST_FETCH && !is_stop(cur) && cur.delay_flag)
      |=> (state_q == ST_WAIT && steps_q == $past(cur.value) && tick_q == '0))
    else $error("wait length not loaded from slot value");

  chk_play_id: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && state_q == ST_FETCH && !is_stop(cur) && !cur.delay_flag)
      |=> (o_wave_start && o_wave_id == $past(cur.value) && state_q == ST_PLAY))
    else $error("play entry did not start its waveform");

  chk_play_index: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_wave_start |-> (o_wave_id == entries[idx_q].value && !entries[idx_q].delay_flag))
    else $error("library index differs from slot");

  chk_go_start: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && state_q == ST_IDLE && i_go) |=> (state_q == ST_FETCH && idx_q == 3'h0))
    else $error("go did not start at first slot");

  chk_advance_next: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && state_q == ST_PLAY && i_wave_done && !last_slot)
      |=> (state_q == ST_FETCH && idx_q == $past(idx_q) + 3'h1))
    else $error("no advance after waveform done");

  chk_stop_end: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && ((state_q == ST_FETCH && is_stop(cur)) || (advance && last_slot)))
      |=> (state_q == ST_IDLE && !o_wave_start))
    else $error("walk did not end at zero slot or eighth slot");

  chk_wait_expire: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && state_q == ST_WAIT && wait_exp)
      |=> (state_q == (($past(last_slot)) ? ST_IDLE : ST_FETCH)))
    else $error("expired wait did not advance");

  // ce low must hold the walk where it stands, or the engine sees stray starts
  chk_ce_freeze: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_ce |=> ($stable(state_q) && $stable(idx_q) && $stable(steps_q) && $stable(tick_q)))
    else $error("sequencer moved while clock enable low");

  chk_state_onehot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $onehot(state_q))
    else $error("sequencer state not one-hot");

  chk_tick_range: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q == ST_WAIT) |-> (tick_q <= TW'(STEP_CYCLES - 1) && steps_q != 7'h00))
    else $error("wait counters out of range");

  // read path: data one cycle behind the request
  chk_read_slot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && i_rd_en && (i_rd_addr == `SEQ_SLOT3_OFFSET || i_rd_addr == `SEQ_SLOT4_OFFSET))
      |=> (o_rd_hit && o_rd_data == (($past(i_rd_addr) == `SEQ_SLOT3_OFFSET) ?
           $past(8'(local_q[0])) : $past(8'(local_q[1])))))
    else $error("slot read did not return stored value");

  chk_read_miss: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && !(i_rd_en && (i_rd_addr == `SEQ_SLOT3_OFFSET || i_rd_addr == `SEQ_SLOT4_OFFSET)))
      |=> (!o_rd_hit && o_rd_data == 8'h00))
    else $error("read data or hit without a slot read");

endmodule : waveform_sequence_slots_3_4

//--- tb/tb_waveform_sequence_slots_3_4.sv
// Purpose: self-checking bench for sequence slots three and four
// Assumes: short wait step (4 cycles) so timed idles stay brief
// Notes:   i_ce dropped briefly in the register and wait scenarios
module tb_waveform_sequence_slots_3_4;
  timeunit 1ns;
  timeprecision 1ps;
  import seq_slots_pkg::*;
  localparam int STEP = 4;
  logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, rd_en = 1'b0, go = 1'b0, done = 1'b0;
  logic [7:0] rd_addr = 8'h00, rd_data;
  reg_wr_t    wr = '0;
  slot_t [5:0] oth = '0;
  logic       rd_hit, wstart, busy, waiting;
  logic [6:0] wid;
  logic [2:0] idx;
  int         n_errors = 0, num_checks = 0, cyc = 0;

  waveform_sequence_slots_3_4 #(.STEP_CYCLES(STEP)) DUT (.i_clk_sys(clk), .i_reset(rst), .i_ce(ce),
    .i_reg_wr(wr), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_hit(rd_hit),
    .i_other_slots(oth), .i_go(go), .i_wave_done(done), .o_wave_start(wstart), .o_wave_id(wid),
    .o_slot_idx(idx), .o_busy(busy), .o_waiting(waiting));

  initial forever #12.5 clk = ~clk;
  // generous ceiling: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) wr <= '{1'b1, a, d};
    @(posedge clk) wr <= '0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk) begin
      rd_en   <= 1'b1;
      rd_addr <= a;
    end
    @(posedge clk) rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
    check({7'h00, rd_hit}, {7'h00, hit});
  endtask : rd_chk

  // waits for a start pulse, checks it, then reports the waveform finished
  task automatic expect_start(input logic [6:0] id, input logic [2:0] ix);
    int k = 0;
    while (wstart !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    check({7'h00, wstart}, 8'h01);
    check({1'b0, wid}, {1'b0, id});
    check({5'h00, idx}, {5'h00, ix});
    check({7'h00, busy}, 8'h01);
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
  endtask : expect_start

  task automatic go_pulse();
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
  endtask : go_pulse

  task automatic expect_idle(input logic [2:0] ix);
    repeat (4) @(posedge clk);
    #1;
    check({7'h00, busy}, 8'h00);
    check({5'h00, idx}, {5'h00, ix});
  endtask : expect_idle

  task automatic t_regs();
    rd_chk(8'h11, 8'h00, 1'b1);
    rd_chk(8'h12, 8'h00, 1'b1);
    wr_reg(8'h11, 8'h85);
    wr_reg(8'h12, 8'h2a);
    wr_reg(8'h13, 8'hff);
    rd_chk(8'h11, 8'h85, 1'b1);
    rd_chk(8'h12, 8'h2a, 1'b1);
    rd_chk(8'h13, 8'h00, 1'b0);
    // frozen clock enable must drop the write
    @(posedge clk) begin
      ce <= 1'b0;
      wr <= '{1'b1, 8'h11, 8'h33};
    end
    @(posedge clk) begin
      ce <= 1'b1;
      wr <= '0;
    end
    rd_chk(8'h11, 8'h85, 1'b1);
  endtask : t_regs

  // play, play, wait of 2 steps, play, then a flagged zero slot stops the walk
  task automatic t_wait_stop();
    int k = 0;
    logic s = 1'b0;
    @(posedge clk) oth <= {8'h00, 8'h00, 8'h00, 8'h80, 8'h06, 8'h05};
    wr_reg(8'h11, 8'h82);
    go_pulse();
    expect_start(7'h05, 3'd0);
    expect_start(7'h06, 3'd1);
    while (waiting !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    check({5'h00, idx}, 8'h02);
    k = 0;
    // one frozen edge in mid-wait stretches it by a cycle
    while (waiting === 1'b1 && k < 100) begin
      s |= wstart;
      k++;
      @(posedge clk);
      ce <= (k == 3) ? 1'b0 : 1'b1;
      #1;
    end
    check(8'(k), 8'(2 * STEP + 1));
    check({7'h00, s}, 8'h00);
    expect_start(7'h2a, 3'd3);
    expect_idle(3'd4);
  endtask : t_wait_stop

  // all eight slots non-zero: walk ends after the last one
  task automatic t_eight();
    @(posedge clk) oth <= {8'h08, 8'h07, 8'h06, 8'h05, 8'h02, 8'h01};
    wr_reg(8'h11, 8'h03);
    wr_reg(8'h12, 8'h04);
    go_pulse();
    for (int i = 0; i < 8; i++) expect_start(7'(i + 1), 3'(i));
    expect_idle(3'd7);
  endtask : t_eight

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_wait_stop();
    t_eight();
    conclude();
  end
endmodule : tb_waveform_sequence_slots_3_4
